// *** pkg/adc_ctl_pkg.sv ***
// Purpose: Shared constants and types for the converter mode and serial control block
// Assumes: 50 MHz system clock, conversion clock made by an enable divider
// Notes: Control codes match on their upper seven bits, the last bit ignored; register codes on the upper three; calibration codes on the full byte
package adc_ctl_pkg;

    // Clock rates and the conversion clock divider
    localparam int unsigned MCLK_HZ = 50_000_000;
    localparam int unsigned TCLK_HZ = 4_096_000;
    localparam int unsigned CLK_DIV = MCLK_HZ / TCLK_HZ; // Rounds down to 12 cycles
    localparam int unsigned DIV_W = 8;
    localparam int unsigned CNT_W = 16;

    // Timing figures in conversion clock periods
    localparam int unsigned CMD_DELAY_TCLK = 2;
    localparam int unsigned RESULT_READY_PIN_PULSE_TCLK = 24;
    localparam int unsigned TIMEOUT_EXP = 15;
    localparam int unsigned TIMEOUT_TCLK = 2 ** TIMEOUT_EXP;
    localparam int unsigned CONV_TCLK = 256; // Length of one conversion, a plain default

    // Result word
    localparam int unsigned RESULT_W = 16;

    // Register offsets whose fields arrive here as ports
    localparam logic [7:0] REG_GAIN = 8'h03;
    localparam logic [7:0] REG_DATARATE = 8'h04;
    localparam logic [7:0] REG_REFCTL = 8'h05;
    localparam logic [7:0] REG_SYSCTL = 8'h09;
    localparam logic [1:0] FIELD_OFF = 2'h0;
    localparam logic MODE_CONT = 1'h0;
    localparam logic MODE_SINGLE = 1'h1;

    // Control commands, first seven bits
    localparam logic [6:0] CMD7_WAKE = 7'h01;
    localparam logic [6:0] CMD7_SLEEP = 7'h02;
    localparam logic [6:0] CMD7_RESET = 7'h03;
    localparam logic [6:0] CMD7_START = 7'h04;
    localparam logic [6:0] CMD7_STOP = 7'h05;
    localparam logic [6:0] CMD7_RDATA = 7'h09;

    // Full byte and prefix commands
    localparam logic [7:0] CMD_SYOCAL = 8'h16;
    localparam logic [7:0] CMD_SYGCAL = 8'h17;
    localparam logic [7:0] CMD_SFOCAL = 8'h19;
    localparam logic [2:0] CMD3_REG_READ_CMD = 3'h1;
    localparam logic [2:0] CMD3_REG_WRITE_CMD = 3'h2;

    // Delayed event bits
    localparam int unsigned EV_SLEEP = 0;
    localparam int unsigned EV_START = 1;
    localparam int unsigned EV_STOP = 2;
    localparam int unsigned EV_PIN = 3;
    localparam int unsigned EV_W = 4;

    // Operating modes
    typedef enum logic [1:0] {MODE_SLEEP, MODE_STANDBY, MODE_CONVERT} op_mode_t;

endpackage

// *** rtl/adc_mode_ctl.sv ***
// Purpose: Operating modes, conversion sequencing and serial port of the converter
// Assumes: Host is an SPI mode 1 controller; all pins are asynchronous to i_mclk
// Notes: Serial clock edges are found by sampling, so it must run well below i_mclk / 4
`timescale 1ns/1ps
module adc_mode_ctl
    import adc_ctl_pkg::*;
#(
    parameter int unsigned CONV_LEN = CONV_TCLK,
    parameter int unsigned TIMEOUT_LEN = TIMEOUT_TCLK,
    parameter int unsigned DIV_LEN = CLK_DIV
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_start_pin,
    input wire logic i_single_shot,
    input wire logic [1:0] i_amp_power_field,
    input wire logic [1:0] i_ref_power_field,
    input wire logic i_timeout_en,
    input wire logic [RESULT_W-1:0] i_sample,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_result_ready_n,
    output logic [1:0] o_op_mode,
    output logic o_filter_rst,
    output logic o_core_clk_en,
    output logic o_amp_on,
    output logic o_ref_on,
    output logic o_excite_on,
    output logic o_reg_read_cmd,
    output logic o_reg_write_cmd,
    output logic o_cal_cmd,
    output logic o_soft_reset
);

    // Whole state of the block
    typedef struct packed {
        logic cs_s1, cs_s2; // Chip select synchroniser
        logic sck_s1, sck_s2, sck_s3; // Serial clock synchroniser and edge stage
        logic din_s1, din_s2; // Data input synchroniser
        logic pin_s1, pin_s2, pin_s3; // Trigger pin synchroniser and edge stage
        logic [DIV_W-1:0] div;    // Conversion clock divider
        op_mode_t mode;           // Operating mode
        logic [2:0] bitcnt;       // Falling edges within the current byte
        logic [7:0] shin;         // Incoming command bits
        logic reading;            // Result readback in progress
        logic [RESULT_W-1:0] sh;  // Outgoing result bits, rotated
        logic [RESULT_W-1:0] result;
        logic result_ready_pin_n;             // Dedicated ready pin
        logic dout;               // Shared output pin
        logic [EV_W-1:0] acc;     // Events since the last clock tick
        logic [EV_W-1:0] p1;      // Events one tick old
        logic [CNT_W-1:0] conv_cnt;
        logic stop_req;           // Finish current conversion then stop
        logic [CNT_W-1:0] to_cnt; // Time spent inside a partial byte
        logic done;               // Conversion completed this cycle
        logic rd_cmd, wr_cmd, cal_cmd, soft_rst; // Command pulses
    } state_t;

    state_t st_r, st_nxt;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_LEN - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_LEN - 1);
    localparam logic [CNT_W-1:0] PULSE_AT = CNT_W'(CONV_LEN - 1 - RESULT_READY_PIN_PULSE_TCLK);
    localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_LEN - 1);

    // Edge and tick terms seen by the next-state logic
    logic tick, sck_fall, sck_rise, pin_rise, pin_fall;
    logic [7:0] byte_in;

    // Stage two versus stage three keeps the first stage private to the chain
    assign tick = (st_r.div == DIV_LAST);
    assign sck_fall = !st_r.cs_s2 && !st_r.sck_s2 && st_r.sck_s3;
    assign sck_rise = !st_r.cs_s2 && st_r.sck_s2 && !st_r.sck_s3;
    assign pin_rise = st_r.pin_s2 && !st_r.pin_s3;
    assign pin_fall = !st_r.pin_s2 && st_r.pin_s3;
    assign byte_in = {st_r.shin[6:0], st_r.din_s2};

    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.cs_s1 = i_cs_n;
        st_nxt.cs_s2 = st_r.cs_s1;
        st_nxt.sck_s1 = i_sclk;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.sck_s3 = st_r.sck_s2;
        st_nxt.din_s1 = i_din;
        st_nxt.din_s2 = st_r.din_s1;
        st_nxt.pin_s1 = i_start_pin;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        st_nxt.done = 1'b0;
        st_nxt.rd_cmd = 1'b0;
        st_nxt.wr_cmd = 1'b0;
        st_nxt.cal_cmd = 1'b0;
        st_nxt.soft_rst = 1'b0;
        st_nxt.div = tick ? '0 : st_r.div + DIV_W'(1);

        // Trigger pin edges count only outside sleep
        if (pin_rise && st_r.mode != MODE_SLEEP)
        begin
            st_nxt.acc[EV_PIN] = 1'b1;
        end
        // Pin low stops continuous conversion after the current one
        if (pin_fall && st_r.mode == MODE_CONVERT && i_single_shot == MODE_CONT)
        begin
            st_nxt.stop_req = 1'b1;
        end

        // Serial input, one bit per falling edge
        if (sck_fall)
        begin
            st_nxt.shin = byte_in;
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
            // Seventh edge decides the control commands except CMD7_RDATA, which waits for the eighth
            if (st_r.bitcnt == 3'h6 && !st_r.reading)
            begin
                case (byte_in[6:0])
                    CMD7_WAKE: st_nxt.mode = (st_r.mode == MODE_SLEEP)
                            ? MODE_STANDBY : st_r.mode;
                    CMD7_SLEEP: st_nxt.acc[EV_SLEEP] = 1'b1;
                    CMD7_RESET:
                    begin
                        // Ignored while asleep since the oscillator is down
                        if (st_r.mode != MODE_SLEEP)
                        begin
                            st_nxt.soft_rst = 1'b1;
                            st_nxt.mode = MODE_STANDBY;
                            st_nxt.stop_req = 1'b0;
                            st_nxt.acc = '0;
                            st_nxt.p1 = '0;
                        end
                    end
                    CMD7_START:
                    begin
                        if (!st_r.pin_s2 && st_r.mode != MODE_SLEEP)
                        begin
                            st_nxt.acc[EV_START] = 1'b1;
                        end
                    end
                    CMD7_STOP: st_nxt.acc[EV_STOP] = 1'b1;
                    default: st_nxt.acc = st_nxt.acc;
                endcase
            end
            // Eighth edge closes the byte
            if (st_r.bitcnt == 3'h7)
            begin
                st_nxt.to_cnt = '0;
                if (!st_r.reading)
                begin
                    if (byte_in[7:1] == CMD7_RDATA)
                    begin
                        st_nxt.reading = 1'b1;
                        st_nxt.sh = st_r.result;
                    end
                    if (byte_in[7:5] == CMD3_REG_READ_CMD)
                    begin
                        st_nxt.rd_cmd = 1'b1;
                    end
                    // Writes are dropped while asleep so settings survive
                    if (byte_in[7:5] == CMD3_REG_WRITE_CMD && st_r.mode != MODE_SLEEP)
                    begin
                        st_nxt.wr_cmd = 1'b1;
                    end
                    if ((byte_in == CMD_SYOCAL || byte_in == CMD_SYGCAL
                            || byte_in == CMD_SFOCAL) && st_r.mode == MODE_CONVERT)
                    begin
                        st_nxt.cal_cmd = 1'b1;
                    end
                end
            end
        end

        // Serial output and ready release on rising edges
        if (sck_rise)
        begin
            st_nxt.result_ready_pin_n = 1'b1;
            if (st_r.reading)
            begin
                // Rotation repeats the word while the clock keeps running
                st_nxt.sh = {st_r.sh[RESULT_W-2:0], st_r.sh[RESULT_W-1]};
            end
        end

        // Timeout on a stalled partial byte, counted in conversion clocks
        if (i_timeout_en && st_r.bitcnt != 3'h0 && tick)
        begin
            if (st_r.to_cnt == TO_LAST)
            begin
                st_nxt.bitcnt = '0;
                st_nxt.reading = 1'b0;
                st_nxt.to_cnt = '0;
            end
            else
            begin
                st_nxt.to_cnt = st_r.to_cnt + CNT_W'(1);
            end
        end

        // Conversion clock work
        if (tick)
        begin
            // Events of the previous period take effect now, two periods late
            st_nxt.p1 = st_nxt.acc;
            st_nxt.acc = '0;
            if (st_r.mode == MODE_CONVERT)
            begin
                if (st_r.conv_cnt == PULSE_AT && !st_r.result_ready_pin_n)
                begin
                    st_nxt.result_ready_pin_n = 1'b1;
                end
                if (st_r.conv_cnt == CONV_LAST)
                begin
                    st_nxt.done = 1'b1;
                    st_nxt.result_ready_pin_n = 1'b0;
                    st_nxt.result = i_sample;
                    st_nxt.conv_cnt = '0;
                    if (i_single_shot == MODE_SINGLE || st_r.stop_req || pin_fall)
                    begin
                        st_nxt.mode = MODE_STANDBY;
                        st_nxt.stop_req = 1'b0;
                    end
                end
                else
                begin
                    st_nxt.conv_cnt = st_r.conv_cnt + CNT_W'(1);
                end
            end
            // Stop only matters in continuous mode
            if (st_r.p1[EV_STOP] && st_r.mode == MODE_CONVERT
                    && i_single_shot == MODE_CONT)
            begin
                st_nxt.stop_req = 1'b1;
            end
            // Pin edge restarts; start begins from standby or while a stop is pending,
            // so a stop then start pair resynchronises even across tick windows
            if (st_r.mode != MODE_SLEEP && !st_nxt.soft_rst && (st_r.p1[EV_PIN]
                    || (st_r.p1[EV_START] && (st_r.mode == MODE_STANDBY
                    || st_r.stop_req || st_r.p1[EV_STOP]))))
            begin
                st_nxt.mode = MODE_CONVERT;
                st_nxt.conv_cnt = '0;
                st_nxt.stop_req = 1'b0;
            end
            // Sleep wins and abandons the conversion
            if (st_r.p1[EV_SLEEP] && !st_nxt.soft_rst)
            begin
                st_nxt.mode = MODE_SLEEP;
                st_nxt.conv_cnt = '0;
                st_nxt.stop_req = 1'b0;
            end
        end

        // Chip select high clears the whole port
        if (st_r.cs_s2)
        begin
            st_nxt.bitcnt = '0;
            st_nxt.shin = '0;
            st_nxt.reading = 1'b0;
            st_nxt.to_cnt = '0;
        end

        // Readback bits move only on rising edges, so the MSB waits for the first one
        st_nxt.dout = !st_nxt.reading ? st_nxt.result_ready_pin_n
                : (sck_rise ? st_r.sh[RESULT_W-1] : st_r.dout);
    end

    // State register; reset lands in standby with ready high
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_r <= '0;
            st_r.cs_s1 <= 1'b1;
            st_r.cs_s2 <= 1'b1;
            st_r.mode <= MODE_STANDBY;
            st_r.result_ready_pin_n <= 1'b1;
            st_r.dout <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign o_dout = st_r.dout;
    assign o_dout_oe = !st_r.cs_s2;
    assign o_result_ready_n = st_r.result_ready_pin_n;
    assign o_op_mode = st_r.mode;
    assign o_filter_rst = (st_r.mode != MODE_CONVERT);
    assign o_core_clk_en = (st_r.mode == MODE_CONVERT);
    assign o_amp_on = (st_r.mode != MODE_SLEEP) && (i_amp_power_field != FIELD_OFF);
    assign o_ref_on = (i_ref_power_field != FIELD_OFF);
    assign o_excite_on = (st_r.mode != MODE_SLEEP) && (i_ref_power_field != FIELD_OFF);
    assign o_reg_read_cmd = st_r.rd_cmd;
    assign o_reg_write_cmd = st_r.wr_cmd;
    assign o_cal_cmd = st_r.cal_cmd;
    assign o_soft_reset = st_r.soft_rst;
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // A command reset in the same cycle cancels the pending sleep
    sequence s_sleep_due;
        tick && st_r.p1[EV_SLEEP] && !st_nxt.soft_rst;
    endsequence
    sequence s_asleep;
        st_r.mode == MODE_SLEEP && !o_core_clk_en;
    endsequence
    a_sleep_entry: assert property (s_sleep_due |=> s_asleep)
        else $error("sleep not entered after delay");
    a_sleep_gate: assert property (st_r.mode == MODE_SLEEP |=> !o_reg_write_cmd && !o_soft_reset)
        else $error("write or reset accepted while asleep");
    a_standby_gate: assert property (st_r.mode == MODE_STANDBY |-> o_filter_rst && !o_core_clk_en)
        else $error("standby without filter reset");
    a_amp_off: assert property (i_amp_power_field == FIELD_OFF |-> !o_amp_on)
        else $error("amplifier on with field zero");
    a_ref_off: assert property (i_ref_power_field == FIELD_OFF |-> !o_ref_on && !o_excite_on)
        else $error("reference on with field zero");
    a_cal_block: assert property (o_cal_cmd |-> $past(st_r.mode) == MODE_CONVERT)
        else $error("calibration decoded outside conversion");
    a_single_end: assert property (st_r.done && i_single_shot == MODE_SINGLE
            && $past(st_r.p1) == '0 |-> st_r.mode == MODE_STANDBY && !o_result_ready_n)
        else $error("single shot did not stop");
    a_ready_share: assert property ($fell(o_result_ready_n) && o_dout_oe && !st_r.reading
            |-> !o_dout)
        else $error("shared pin missed ready fall");
    a_ready_rise: assert property (sck_rise && !st_nxt.done |=> o_result_ready_n)
        else $error("ready not released by serial clock");
    a_cs_reset: assert property (st_r.cs_s2 |=> st_r.bitcnt == 3'h0 && !st_r.reading ##1 1)
        else $error("port not reset with select high");
    a_start_delay: assert property (tick && st_r.p1[EV_START] && !st_r.p1[EV_SLEEP]
            && st_r.mode == MODE_STANDBY && !st_nxt.soft_rst |=> st_r.mode == MODE_CONVERT)
        else $error("start not applied");
endmodule

// *** verif/adc_mode_ctl_tb.sv ***
// Purpose: Self-checking bench for the converter mode and serial control block
// Assumes: Short conversion (32 ticks) and short timeout for a quick run
// Notes: Readback words are queued by the driver and checked by the monitor
`timescale 1ns/1ps
module adc_mode_ctl_tb;
    import adc_ctl_pkg::*;
    logic clk, rst_n, cs_n, sclk, din, pin, single, tmo_en, miso, miso_last, rd_valid;
    logic [1:0] amp_f, ref_f, mode;
    logic [15:0] sample, rd_word;
    logic dout, dout_oe, rdy_n, filt_rst, core_en, amp_on, ref_on, exc_on;
    logic reg_read_cmd_p, reg_write_cmd_p, cal_p, srst_p;
    int num_errors, checked, cycles, seed, n_rd, n_wr, n_cal, n_rst;
    logic [15:0] exp_q[$]; // Expected readback words, oldest first

    adc_mode_ctl #(.CONV_LEN(32), .TIMEOUT_LEN(16)) dut (.i_mclk(clk), .i_rst_n(rst_n),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .i_start_pin(pin), .i_single_shot(single),
        .i_amp_power_field(amp_f), .i_ref_power_field(ref_f), .i_timeout_en(tmo_en),
        .i_sample(sample), .o_dout(dout), .o_dout_oe(dout_oe), .o_result_ready_n(rdy_n),
        .o_op_mode(mode), .o_filter_rst(filt_rst), .o_core_clk_en(core_en), .o_amp_on(amp_on),
        .o_ref_on(ref_on), .o_excite_on(exc_on), .o_reg_read_cmd(reg_read_cmd_p),
        .o_reg_write_cmd(reg_write_cmd_p), .o_cal_cmd(cal_p), .o_soft_reset(srst_p));

    spi_host_model host (.i_mclk(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_mosi(din), .o_rd_valid(rd_valid), .o_rd_word(rd_word));

    // Released data line shows the inverse of its last driven level, never a stale copy
    assign miso = dout_oe ? dout : ~miso_last;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Remember the last driven level and count command pulses
    always @(posedge clk)
    begin
        if (dout_oe === 1'b1) miso_last <= dout;
        if (reg_read_cmd_p === 1'b1) n_rd++;
        if (reg_write_cmd_p === 1'b1) n_wr++;
        if (cal_p === 1'b1) n_cal++;
        if (srst_p === 1'b1) n_rst++;
    end

    task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic s);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, e, s);
        end
    endtask

    // Bounded wait for a mode, then a compare at a settled point
    task automatic wait_mode(input op_mode_t m, input int lim);
        for (int n = 0; n < lim && mode !== 2'(m); n++) @(negedge clk);
        cmp_word("op_mode", 16'(m), 16'(mode));
    endtask

    task automatic wait_rdy(input logic v, input int lim);
        for (int n = 0; n < lim && rdy_n !== v; n++) @(negedge clk);
        cmp_bit("result_ready_n", v, rdy_n);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Monitor: each reported readback word is matched against the oldest note
    always @(posedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp_word("readback", 16'hxxxx, rd_word);
            else
                cmp_word("readback", exp_q.pop_front(), rd_word);
        end
    end

    // Hang guard well beyond the expected few thousand cycles
    initial
    begin
        for (cycles = 0; cycles < 30000; cycles++) @(posedge clk);
        num_errors++;
        $display("Error run_length expected done seen hang");
        conclude();
    end

    // Main sequence
    initial
    begin
        seed = 10;
        rst_n = 1'b0;
        pin = 1'b0;
        single = MODE_CONT;
        tmo_en = 1'b1;
        miso_last = 1'b0;
        amp_f = 2'b01 | 2'($random(seed));
        ref_f = 2'b01 | 2'($random(seed));
        sample = 16'($random(seed));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp_word("op_mode", 16'(MODE_STANDBY), 16'(mode));
        cmp_bit("result_ready_n", 1'b1, rdy_n);
        cmp_bit("filter_rst", 1'b1, filt_rst);
        cmp_bit("core_clk_en", 1'b0, core_en);
        cmp_bit("dout_oe", 1'b0, dout_oe);
        end_test("reset");
        // Continuous run; second result overwrites an unread first one
        host.cmd({CMD7_START, 1'b0});
        wait_mode(MODE_CONVERT, 60);
        cmp_bit("core_clk_en", 1'b1, core_en);
        wait_rdy(1'b0, 600);
        @(posedge clk) sample <= 16'($random(seed));
        wait_rdy(1'b1, 600);
        wait_rdy(1'b0, 600);
        exp_q.push_back(sample);
        host.read_word();
        cmp_bit("result_ready_n", 1'b1, rdy_n);
        cmp_bit("dout_oe", 1'b0, dout_oe);
        // Stop then start back to back must keep converting; then calibrate while running
        host.cmd({CMD7_STOP, 1'b0});
        host.cmd({CMD7_START, 1'b0});
        wait_rdy(1'b0, 600);
        cmp_word("op_mode", 16'(MODE_CONVERT), 16'(mode));
        host.cmd(CMD_SYOCAL);
        cmp_word("cal_pulses", 16'h0001, 16'(n_cal));
        host.cmd({CMD7_STOP, 1'b0});
        wait_mode(MODE_STANDBY, 900);
        cmp_bit("result_ready_n", 1'b0, rdy_n);
        end_test("continuous");
        // Single shot by pin, then a start command refused while the pin is high
        @(posedge clk) single <= MODE_SINGLE;
        @(posedge clk) pin <= 1'b1;
        wait_mode(MODE_CONVERT, 60);
        wait_mode(MODE_STANDBY, 600);
        repeat (500) @(negedge clk);
        cmp_word("op_mode", 16'(MODE_STANDBY), 16'(mode));
        host.cmd({CMD7_START, 1'b0});
        repeat (60) @(negedge clk);
        cmp_word("op_mode", 16'(MODE_STANDBY), 16'(mode));
        @(posedge clk) pin <= 1'b0;
        end_test("single_shot");
        // Sleep: pin ignored, write and reset refused, register read served
        host.cmd({CMD7_SLEEP, 1'b0});
        wait_mode(MODE_SLEEP, 60);
        @(posedge clk) pin <= 1'b1;
        repeat (60) @(negedge clk);
        cmp_word("op_mode", 16'(MODE_SLEEP), 16'(mode));
        @(posedge clk) pin <= 1'b0;
        host.cmd({CMD3_REG_WRITE_CMD, 5'h03});
        host.cmd({CMD7_RESET, 1'b0});
        host.cmd({CMD3_REG_READ_CMD, 5'h04});
        cmp_word("write_pulses", 16'h0000, 16'(n_wr));
        cmp_word("reset_pulses", 16'h0000, 16'(n_rst));
        cmp_word("read_pulses", 16'h0001, 16'(n_rd));
        host.cmd({CMD7_WAKE, 1'b0});
        wait_mode(MODE_STANDBY, 60);
        end_test("sleep");
        // Standby: write accepted, calibration refused, power fields at zero
        host.cmd({CMD3_REG_WRITE_CMD, 5'h03});
        host.cmd(CMD_SYOCAL);
        cmp_word("write_pulses", 16'h0001, 16'(n_wr));
        cmp_word("cal_pulses", 16'h0001, 16'(n_cal));
        @(posedge clk)
        begin
            amp_f <= FIELD_OFF;
            ref_f <= FIELD_OFF;
        end
        repeat (2) @(negedge clk);
        cmp_bit("amp_on", 1'b0, amp_on);
        cmp_bit("ref_on", 1'b0, ref_on);
        cmp_bit("excite_on", 1'b0, exc_on);
        end_test("standby");
        conclude();
    end
endmodule

// *** verif/spi_host_model.sv ***
// Purpose: SPI mode 1 host stand-in that frames command bytes and reads results
// Assumes: Serial clock period of eight system clocks (160 ns), idle low
// Notes: Data out is sampled three and a half clocks after each falling edge to clear the sync delay
`timescale 1ns/1ps
module spi_host_model
    import adc_ctl_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_miso,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi,
    output logic o_rd_valid,
    output logic [15:0] o_rd_word
);
    // Idle levels: deselected, clock parked low, data input low
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_word = 16'h0000;
    end

    // One byte, MSB first; data moves on the rising edge so it is stable at the fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge i_mclk);
            o_sclk <= 1'b1;
            o_mosi <= tx[i];
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b0;
            repeat (3) @(posedge i_mclk);
            @(negedge i_mclk);
            rx[i] = i_miso;
        end
    endtask

    // Whole frame: select, command byte, optional read bytes, deselect
    task automatic frame(input logic [7:0] b0, input int nrd, output logic [15:0] word);
        logic [7:0] r;
        word = 16'h0000;
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        xfer(b0, r);
        for (int k = 0; k < nrd; k++)
        begin
            xfer(8'h00, r);
            word = {word[7:0], r};
        end
        repeat (4) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        o_mosi <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask

    // Single command byte in its own frame
    task automatic cmd(input logic [7:0] b0);
        logic [15:0] w;
        frame(b0, 0, w);
    endtask

    // Result read: two bytes after the read command, then a one-cycle report
    task automatic read_word();
        logic [15:0] w;
        frame({CMD7_RDATA, 1'b0}, 2, w);
        o_rd_word <= w;
        o_rd_valid <= 1'b1;
        @(posedge i_mclk);
        o_rd_valid <= 1'b0;
    endtask
endmodule
